// file: logic/hfd_defs.svh
// Register map, field positions and reset values of the host FIFO data path
// ***************************************************************************
// Overview of operation
// [R1] Flag transmit error when supplied buffer bytes differ from packet length.
// [R2] Both commands per buffer; second command must match across a packet.
// [R3] Flag transmit error when host writes data into a full data FIFO.
// [R4] Flag transmit error on status FIFO overrun unless overrun-allow is set.
// [R5] Transmitter keeps running after any transmit error.
// [R6] Halt request lets the frame in flight finish first.
// [R7] After last status, clear halt and enable, pulse the halted event.
// [R8] Host may purge, then sets enable; queued frames then go out.
// [R9] Receive data goes to data FIFO first, status word afterwards.
// [R10] Host may read statuses before data; levels shown in level register.
// [R11] Reading empty receive FIFO raises receive error; only soft reset clears.
// [R12] Each receive packet starts shifted by offset of 0 to 31 bytes.
// [R13] Host changes the receive offset only between packets.
// [R14] Optional filler pads each packet to a multiple of the burst.
// [R15] Offset and padding apply to each packet of a continuous stream.
// [R16] Host reads length plus offset plus padding worth of data.
// [R17] Skip bit drops head packet from data FIFO, then clears itself.
// [R18] Host skips only packets of at least four words.
// [R19] Host reads no receive or transmit status FIFO while skip pends.
// [R20] Skip touches only the data FIFO; its status stays queued.
// [R21] Skip works while the receiver keeps running.
// [R22] Flush bit resets both receive FIFOs, then clears itself.
// [R23] With overrun-allow, keep sending with full status FIFO, drop status.
// ***************************************************************************
`ifndef HFD_DEFS_SVH
`define HFD_DEFS_SVH
`define HFD_A_RXDATA 8'h00
`define HFD_A_RXSTAT 8'h04
`define HFD_A_TXDATA 8'h08
`define HFD_A_TXSTAT 8'h0C
`define HFD_A_RXCFG 8'h10
`define HFD_A_TXCFG 8'h14
`define HFD_A_DPCTRL 8'h18
`define HFD_A_LEVEL 8'h1C
`define HFD_A_FLAGS 8'h20
`define HFD_RXCFG_OFF 4:0
`define HFD_RXCFG_PAD 9:8
`define HFD_RXCFG_FLUSH 15
`define HFD_TXCFG_ON 0
`define HFD_TXCFG_HALT 1
`define HFD_TXCFG_SAO 2
`define HFD_DP_SKIP 31
`define HFD_FL_TXE 0
`define HFD_FL_RXE 1
`define HFD_FL_SRST 31
`define HFD_LV_DATA 15:0
`define HFD_LV_STAT 23:16
`define HFD_TXA_SZ 10:0
`define HFD_TXA_LS 12
`define HFD_TXA_FS 13
`define HFD_TXB_LEN 10:0
`define HFD_PAD_NONE 2'h0
`define HFD_PAD_4 2'h1
`define HFD_PAD_8 2'h2
`define HFD_MASK_4 4'h3
`define HFD_MASK_8 4'h7
`define HFD_MASK_16 4'hF
`define HFD_ZERO32 32'h0000_0000
`define HFD_RST_OFF 5'h00
`define HFD_RST_PAD 2'h0
`endif

// file: logic/hfd_pkg.sv
// Types shared by the host FIFO data path
package hfd_pkg;
  typedef enum logic [2:0] {
    TXP_A = 3'b001,
    TXP_B = 3'b010,
    TXP_D = 3'b100
  } hfd_txp_t;
  typedef enum logic [4:0] {
    W_IDLE = 5'b00001,
    W_LEAD = 5'b00010,
    W_DATA = 5'b00100,
    W_CARRY = 5'b01000,
    W_PAD = 5'b10000
  } hfd_wr_t;
endpackage

// file: logic/hfd_fifo.sv
// Synchronous FIFO with flush, head visible without a pop
module hfd_fifo
  import hfd_pkg::*;
#(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  output logic [W-1:0] rd_data,
  output logic full,
  output logic empty,
  output logic [AW:0] used
);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("hfd_fifo DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire do_wr = wr_en && !full;
  wire do_rd = rd_en && !empty;

  assign used = wptr_ff - rptr_ff;
  assign full = used[AW];
  assign empty = (used == '0);
  assign rd_data = mem[rptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wptr_ff[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else if (flush) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (do_wr) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (do_rd) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
    end
  end
endmodule

// file: logic/hfd_datapath.sv
// Host-facing transmit and receive FIFO data path control
`include "hfd_defs.svh"
module hfd_datapath
  import hfd_pkg::*;
#(
  parameter int RXD_DEPTH = 64,
  parameter int RXS_DEPTH = 16,
  parameter int TXD_DEPTH = 64,
  parameter int TXS_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [31:0] tx_mac_data,
  output logic tx_mac_last,
  output logic tx_mac_valid,
  input wire logic tx_mac_ready,
  input wire logic [31:0] tx_mac_stat,
  input wire logic tx_mac_stat_valid,
  input wire logic [31:0] rx_mil_data,
  input wire logic rx_mil_last,
  input wire logic [1:0] rx_mil_bytes,
  input wire logic rx_mil_valid,
  output logic rx_mil_ready,
  input wire logic [31:0] rx_mil_stat,
  input wire logic rx_mil_stat_valid,
  output logic rx_mil_stat_ready,
  output logic tx_error_flag,
  output logic rx_error_flag,
  output logic tx_halted_irq
);
  generate
    if (RXD_DEPTH < 4 || RXD_DEPTH > 32768 || RXS_DEPTH > 128) begin : g_chk
      $error("hfd_datapath FIFO depths out of range");
    end
  endgenerate

  localparam int RDW = $clog2(RXD_DEPTH);
  localparam int RSW = $clog2(RXS_DEPTH);
  localparam int TDW = $clog2(TXD_DEPTH);
  localparam int TSW = $clog2(TXS_DEPTH);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ***********************************************************************
  // Register decode
  // ***********************************************************************
  wire rd_rxdata = reg_rd && hit(reg_addr, `HFD_A_RXDATA);
  wire rd_rxstat = reg_rd && hit(reg_addr, `HFD_A_RXSTAT);
  wire rd_txstat = reg_rd && hit(reg_addr, `HFD_A_TXSTAT);
  wire wr_txdata = reg_wr && hit(reg_addr, `HFD_A_TXDATA);
  wire wr_rxcfg = reg_wr && hit(reg_addr, `HFD_A_RXCFG);
  wire wr_txcfg = reg_wr && hit(reg_addr, `HFD_A_TXCFG);
  wire wr_dp = reg_wr && hit(reg_addr, `HFD_A_DPCTRL);
  wire wr_flags = reg_wr && hit(reg_addr, `HFD_A_FLAGS);

  logic [4:0] rx_off_ff;
  logic [1:0] rx_pad_ff;
  logic flush_ff;
  logic on_ff;
  logic halt_ff;
  logic sao_ff;
  logic skip_ff;
  logic txe_ff;
  logic rxe_ff;
  logic halted_ff;
  logic soft_ff;
  logic [31:0] rdata_ff;

  // FIFO wiring
  logic [32:0] rxd_q;
  logic rxd_full;
  logic rxd_empty;
  logic [RDW:0] rxd_used;
  logic rxd_wr;
  logic [32:0] rxd_wdata;
  logic [31:0] rxs_q;
  logic rxs_full;
  logic rxs_empty;
  logic [RSW:0] rxs_used;
  logic [32:0] txd_q;
  logic txd_full;
  logic txd_empty;
  logic [31:0] txs_q;
  logic txs_full;
  logic txs_empty;

  wire fifo_clr = flush_ff || soft_ff;
  wire skip_pop = skip_ff && !rxd_empty; // R20
  wire host_rxd_pop = rd_rxdata && !rxd_empty;
  wire rxd_rd = skip_pop || host_rxd_pop;
  wire stat_accept = rx_mil_stat_valid && rx_mil_stat_ready;
  wire txs_wr = tx_mac_stat_valid && !txs_full;
  wire stat_ovr = tx_mac_stat_valid && txs_full && !sao_ff;

  // ***********************************************************************
  // Transmit command parser
  // ***********************************************************************
  hfd_txp_t txp_ff;
  logic [10:0] bsize_ff;
  logic fs_ff;
  logic ls_ff;
  logic [8:0] wleft_ff;
  logic [10:0] plen_ff;
  logic [31:0] cmdb_ff;
  logic [10:0] bsum_ff;

  wire [8:0] bwords = 9'((12'(bsize_ff) + 12'd3) >> 2);
  wire [10:0] nxt_bsum = (fs_ff ? 11'd0 : bsum_ff) + bsize_ff;
  wire [10:0] cur_len = fs_ff ? reg_wdata[`HFD_TXB_LEN] : plen_ff;
  wire in_a = wr_txdata && txp_ff == TXP_A;
  wire in_b = wr_txdata && txp_ff == TXP_B;
  wire in_d = wr_txdata && txp_ff == TXP_D;
  wire b_mism = in_b && !fs_ff && reg_wdata != cmdb_ff;
  wire len_err = in_b && ls_ff && nxt_bsum != cur_len;
  wire host_ovr = in_d && txd_full;
  wire txd_wr = in_d && !txd_full;
  wire [32:0] txd_wdata = {ls_ff && wleft_ff == 9'd1, reg_wdata};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txp_ff <= TXP_A;
      bsize_ff <= '0;
      fs_ff <= 1'b0;
      ls_ff <= 1'b0;
      wleft_ff <= '0;
      plen_ff <= '0;
      cmdb_ff <= `HFD_ZERO32;
      bsum_ff <= '0;
    end else if (soft_ff) begin
      txp_ff <= TXP_A;
    end else if (in_a) begin
      bsize_ff <= reg_wdata[`HFD_TXA_SZ];
      fs_ff <= reg_wdata[`HFD_TXA_FS];
      ls_ff <= reg_wdata[`HFD_TXA_LS];
      txp_ff <= TXP_B;
    end else if (in_b) begin
      if (fs_ff) begin
        cmdb_ff <= reg_wdata;
        plen_ff <= reg_wdata[`HFD_TXB_LEN];
      end
      bsum_ff <= nxt_bsum;
      wleft_ff <= bwords;
      txp_ff <= (bwords == 9'd0) ? TXP_A : TXP_D;
    end else if (in_d) begin
      wleft_ff <= wleft_ff - 9'd1;
      if (wleft_ff == 9'd1) begin
        txp_ff <= TXP_A;
      end
    end
  end

  // ***********************************************************************
  // Transmit engine, halt and restart
  // ***********************************************************************
  logic in_frame_ff;
  logic [7:0] pend_ff;
  logic tx_valid_ff;
  logic tx_last_ff;
  logic [31:0] tx_data_ff;

  // Full status FIFO holds back new frames unless overrun is allowed
  wire stat_block = txs_full && !sao_ff;
  wire may_start = on_ff && (in_frame_ff || !(halt_ff || stat_block)); // R6 R23
  wire tx_pop = may_start && !txd_empty && (!tx_valid_ff || tx_mac_ready);
  wire pend_dec = tx_mac_stat_valid && pend_ff != 8'd0;
  wire pend_inc = tx_pop && txd_q[32];
  wire halt_done = on_ff && halt_ff && !in_frame_ff && !tx_valid_ff &&
                   pend_ff == 8'd0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_frame_ff <= 1'b0;
      pend_ff <= '0;
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
      tx_data_ff <= `HFD_ZERO32;
    end else if (soft_ff) begin
      in_frame_ff <= 1'b0;
      pend_ff <= '0;
      tx_valid_ff <= 1'b0;
    end else begin
      pend_ff <= pend_ff + {7'd0, pend_inc} - {7'd0, pend_dec};
      if (tx_pop) begin
        tx_valid_ff <= 1'b1;
        tx_data_ff <= txd_q[31:0];
        tx_last_ff <= txd_q[32];
        in_frame_ff <= !txd_q[32];
      end else if (tx_mac_ready) begin
        tx_valid_ff <= 1'b0;
      end
    end
  end

  // ***********************************************************************
  // Receive writer: offset, shift, carry and end padding per packet
  // ***********************************************************************
  hfd_wr_t wst_ff;
  hfd_wr_t nxt_wst;
  logic [2:0] lead_ff;
  logic [1:0] sh_ff;
  logic [3:0] mask_ff;
  logic [3:0] cnt_ff;
  logic [31:0] carry_ff;
  logic rdy_ff;
  logic srdy_ff;

  wire [63:0] wide = {32'd0, rx_mil_data} << {sh_ff, 3'b000};
  wire [2:0] spill = {1'b0, sh_ff} + {1'b0, rx_mil_bytes};
  wire take = wst_ff == W_DATA && rx_mil_valid && rdy_ff;
  wire [3:0] nxt_cnt = cnt_ff + 4'd1;
  wire pad_more = (nxt_cnt & mask_ff) != 4'd0;
  wire [3:0] cfg_mask = rx_pad_ff == `HFD_PAD_NONE ? 4'h0 :
                        rx_pad_ff == `HFD_PAD_4 ? `HFD_MASK_4 :
                        rx_pad_ff == `HFD_PAD_8 ? `HFD_MASK_8 : `HFD_MASK_16;

  always_comb begin
    nxt_wst = wst_ff;
    rxd_wr = 1'b0;
    rxd_wdata = 33'd0;
    unique case (wst_ff)
      W_IDLE: begin
        if (rx_mil_valid) begin
          nxt_wst = (rx_off_ff[4:2] != 3'd0) ? W_LEAD : W_DATA; // R12 R15
        end
      end
      W_LEAD: begin
        rxd_wr = !rxd_full;
        if (rxd_wr && lead_ff == 3'd1) begin
          nxt_wst = W_DATA;
        end
      end
      W_DATA: begin
        rxd_wr = take;
        rxd_wdata = {1'b0, wide[31:0] | carry_ff};
        if (take && rx_mil_last) begin
          nxt_wst = (sh_ff != 2'd0 && spill[2]) ? W_CARRY :
                    pad_more ? W_PAD : W_IDLE; // R14
        end
      end
      W_CARRY: begin
        rxd_wr = !rxd_full;
        rxd_wdata = {1'b0, carry_ff};
        if (rxd_wr) begin
          nxt_wst = pad_more ? W_PAD : W_IDLE;
        end
      end
      W_PAD: begin
        rxd_wr = !rxd_full;
        if (rxd_wr && !pad_more) begin
          nxt_wst = W_IDLE;
        end
      end
    endcase
    // Packet boundary mark lets skip find the next packet start
    if (rxd_wr && nxt_wst == W_IDLE) begin
      rxd_wdata[32] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wst_ff <= W_IDLE;
      lead_ff <= '0;
      sh_ff <= '0;
      mask_ff <= '0;
      cnt_ff <= '0;
      carry_ff <= `HFD_ZERO32;
      rdy_ff <= 1'b0;
      srdy_ff <= 1'b0;
    end else if (fifo_clr) begin
      wst_ff <= W_IDLE;
      rdy_ff <= 1'b0;
      srdy_ff <= 1'b0;
    end else begin
      wst_ff <= nxt_wst;
      // Registered ready, so leave one spare word of room
      rdy_ff <= nxt_wst == W_DATA && rxd_used < RDW'(RXD_DEPTH - 1);
      // Status only once the packet data is fully queued
      srdy_ff <= nxt_wst == W_IDLE && !stat_accept && !rxs_full; // R9
      if (wst_ff == W_IDLE) begin
        lead_ff <= rx_off_ff[4:2];
        sh_ff <= rx_off_ff[1:0];
        mask_ff <= cfg_mask;
        cnt_ff <= '0;
        carry_ff <= `HFD_ZERO32;
      end else if (rxd_wr) begin
        cnt_ff <= nxt_cnt;
        lead_ff <= lead_ff - 3'd1;
        if (take) begin
          carry_ff <= wide[63:32];
        end
      end
    end
  end

  // ***********************************************************************
  // Control registers and flags
  // ***********************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_off_ff <= `HFD_RST_OFF;
      rx_pad_ff <= `HFD_RST_PAD;
      flush_ff <= 1'b0;
      on_ff <= 1'b0;
      halt_ff <= 1'b0;
      sao_ff <= 1'b0;
      skip_ff <= 1'b0;
      txe_ff <= 1'b0;
      rxe_ff <= 1'b0;
      halted_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else if (soft_ff) begin
      rx_off_ff <= `HFD_RST_OFF;
      rx_pad_ff <= `HFD_RST_PAD;
      flush_ff <= 1'b0;
      on_ff <= 1'b0;
      halt_ff <= 1'b0;
      sao_ff <= 1'b0;
      skip_ff <= 1'b0;
      txe_ff <= 1'b0;
      rxe_ff <= 1'b0;
      halted_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else begin
      soft_ff <= wr_flags && reg_wdata[`HFD_FL_SRST];
      halted_ff <= halt_done; // R7
      if (wr_rxcfg) begin
        rx_off_ff <= reg_wdata[`HFD_RXCFG_OFF];
        rx_pad_ff <= reg_wdata[`HFD_RXCFG_PAD];
      end
      flush_ff <= wr_rxcfg && reg_wdata[`HFD_RXCFG_FLUSH]; // R22
      if (wr_txcfg) begin
        on_ff <= reg_wdata[`HFD_TXCFG_ON]; // R8
        halt_ff <= reg_wdata[`HFD_TXCFG_HALT];
        sao_ff <= reg_wdata[`HFD_TXCFG_SAO];
      end else if (halt_done) begin
        on_ff <= 1'b0; // R7
        halt_ff <= 1'b0;
      end
      if (wr_dp && reg_wdata[`HFD_DP_SKIP]) begin
        skip_ff <= 1'b1;
      end else if (skip_pop && rxd_q[32]) begin
        skip_ff <= 1'b0; // R17 R21
      end
      // Error causes never stop the engine; set wins over clear
      if (host_ovr || b_mism || len_err || stat_ovr) begin
        txe_ff <= 1'b1; // R1 R2 R3 R4 R5
      end else if (wr_flags && reg_wdata[`HFD_FL_TXE]) begin
        txe_ff <= 1'b0;
      end
      if ((rd_rxdata && rxd_empty) || (rd_rxstat && rxs_empty)) begin
        rxe_ff <= 1'b1; // R11
      end
    end
  end

  // ***********************************************************************
  // Read data, valid only in the cycle after the strobe
  // ***********************************************************************
  wire [31:0] lvl = {8'd0, 8'(rxs_used), 16'(rxd_used)}; // R10
  wire [31:0] cfg_rx = {16'd0, flush_ff, 5'd0, rx_pad_ff, 3'd0, rx_off_ff};
  wire [31:0] cfg_tx = {29'd0, sao_ff, halt_ff, on_ff};
  wire [31:0] flags = {30'd0, rxe_ff, txe_ff};
  wire [31:0] rmux =
    hit(reg_addr, `HFD_A_RXDATA) ? (rxd_empty ? `HFD_ZERO32 : rxd_q[31:0]) :
    hit(reg_addr, `HFD_A_RXSTAT) ? (rxs_empty ? `HFD_ZERO32 : rxs_q) :
    hit(reg_addr, `HFD_A_TXSTAT) ? (txs_empty ? `HFD_ZERO32 : txs_q) :
    hit(reg_addr, `HFD_A_RXCFG) ? cfg_rx :
    hit(reg_addr, `HFD_A_TXCFG) ? cfg_tx :
    hit(reg_addr, `HFD_A_DPCTRL) ? {skip_ff, 31'd0} :
    hit(reg_addr, `HFD_A_LEVEL) ? lvl :
    hit(reg_addr, `HFD_A_FLAGS) ? flags : `HFD_ZERO32;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `HFD_ZERO32;
    end else begin
      rdata_ff <= reg_rd ? rmux : `HFD_ZERO32;
    end
  end

  // ***********************************************************************
  // FIFOs
  // ***********************************************************************
  hfd_fifo #(.W(33), .DEPTH(RXD_DEPTH)) u_rxd (
    .sys_clk(sys_clk), .rst(rst), .flush(fifo_clr),
    .wr_en(rxd_wr), .wr_data(rxd_wdata), .rd_en(rxd_rd), .rd_data(rxd_q),
    .full(rxd_full), .empty(rxd_empty), .used(rxd_used)
  );
  hfd_fifo #(.W(32), .DEPTH(RXS_DEPTH)) u_rxs (
    .sys_clk(sys_clk), .rst(rst), .flush(fifo_clr),
    .wr_en(stat_accept), .wr_data(rx_mil_stat), .rd_en(rd_rxstat),
    .rd_data(rxs_q), .full(rxs_full), .empty(rxs_empty), .used(rxs_used)
  );
  hfd_fifo #(.W(33), .DEPTH(TXD_DEPTH)) u_txd (
    .sys_clk(sys_clk), .rst(rst), .flush(soft_ff),
    .wr_en(txd_wr), .wr_data(txd_wdata), .rd_en(tx_pop), .rd_data(txd_q),
    .full(txd_full), .empty(txd_empty), .used()
  );
  hfd_fifo #(.W(32), .DEPTH(TXS_DEPTH)) u_txs (
    .sys_clk(sys_clk), .rst(rst), .flush(soft_ff),
    .wr_en(txs_wr), .wr_data(tx_mac_stat), .rd_en(rd_txstat),
    .rd_data(txs_q), .full(txs_full), .empty(txs_empty), .used()
  );

  assign reg_rdata = rdata_ff;
  assign tx_mac_data = tx_data_ff;
  assign tx_mac_last = tx_last_ff;
  assign tx_mac_valid = tx_valid_ff;
  assign rx_mil_ready = rdy_ff;
  assign rx_mil_stat_ready = srdy_ff;
  assign tx_error_flag = txe_ff;
  assign rx_error_flag = rxe_ff;
  assign tx_halted_irq = halted_ff;

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_host_overrun: assert property (in_d && txd_full && !soft_ff |=> txe_ff) // R3
    else $error("host overrun did not raise tx error");
  a_stat_overrun: assert property (stat_ovr && !soft_ff |=> txe_ff) // R4
    else $error("status overrun did not raise tx error");
  a_sao_drop: assert property (sao_ff && txs_full |-> !txs_wr && !stat_block) // R23
    else $error("status written or engine blocked while overrun allowed");
  a_halt_end: assert property (halt_done && !wr_txcfg && !soft_ff
    |=> tx_halted_irq && !on_ff && !halt_ff ##1 !tx_halted_irq) // R7
    else $error("halt completion wrong");
  a_halt_frame: assert property (halt_ff && in_frame_ff |-> !halt_done) // R6
    else $error("halt taken inside a frame");
  a_rx_underrun: assert property (rd_rxdata && rxd_empty |=> ##[0:1] rx_error_flag) // R11
    else $error("rx underrun not flagged");
  a_rxe_sticky: assert property (rx_error_flag && !soft_ff |=> rx_error_flag) // R11
    else $error("rx error cleared without soft reset");
  a_flush_done: assert property (flush_ff |=> !flush_ff && rxd_empty && rxs_empty) // R22
    else $error("flush did not empty the rx FIFOs");
  a_skip_end: assert property (skip_pop && rxd_q[32] && !wr_dp && !soft_ff
    |=> !skip_ff) // R17
    else $error("skip bit not cleared at packet end");
  a_lead_zero: assert property (wst_ff == W_LEAD && rxd_wr |-> rxd_wdata == 33'd0) // R12
    else $error("offset lead word not zero");
  a_status_after: assert property (stat_accept |-> wst_ff == W_IDLE) // R9
    else $error("status stored before its data");
endmodule

// file: tb/hfd_mac_model.sv
// Behavioural MAC side partner: transmit sink and receive source
module hfd_mac_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] tx_mac_data,
  input wire logic tx_mac_last,
  input wire logic tx_mac_valid,
  output logic tx_mac_ready,
  output logic [31:0] tx_mac_stat,
  output logic tx_mac_stat_valid,
  output logic [31:0] rx_mil_data,
  output logic rx_mil_last,
  output logic [1:0] rx_mil_bytes,
  output logic rx_mil_valid,
  input wire logic rx_mil_ready,
  output logic [31:0] rx_mil_stat,
  output logic rx_mil_stat_valid,
  input wire logic rx_mil_stat_ready,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_mil_data = 32'h0000_0000;
    rx_mil_last = 1'b0;
    rx_mil_bytes = 2'h0;
    rx_mil_valid = 1'b0;
    rx_mil_stat = 32'h0000_0000;
    rx_mil_stat_valid = 1'b0;
  end
  // Ready toggles every cycle so the sender always sees stalls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_mac_ready <= 1'b0;
      tx_mac_stat_valid <= 1'b0;
      tx_mac_stat <= 32'h0000_0000;
      frames <= 0;
    end else begin
      tx_mac_ready <= ~tx_mac_ready;
      tx_mac_stat_valid <= tx_mac_valid && tx_mac_ready && tx_mac_last;
      tx_mac_stat <= 32'h0001_0000;
      if (tx_mac_valid && tx_mac_ready && tx_mac_last) begin
        frames <= frames + 1;
      end
    end
  end
  // Data beats first, status word last; released data and status are then driven inverted
  task automatic rx_pkt(input int n, input logic [31:0] base, input logic [31:0] stat);
    @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rx_mil_data <= base + 32'(i);
      rx_mil_last <= (i == n - 1);
      rx_mil_bytes <= 2'h3;
      rx_mil_valid <= 1'b1;
      do @(posedge sys_clk); while (rx_mil_ready !== 1'b1);
    end
    rx_mil_valid <= 1'b0;
    rx_mil_data <= ~base;
    rx_mil_stat <= stat;
    rx_mil_stat_valid <= 1'b1;
    do @(posedge sys_clk); while (rx_mil_stat_ready !== 1'b1);
    rx_mil_stat_valid <= 1'b0;
    rx_mil_stat <= ~stat;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the host FIFO data path
`include "hfd_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] e;} hfd_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, tx_mac_data, tx_mac_stat, rx_mil_data, rx_mil_stat, d;
  logic tx_mac_last, tx_mac_valid, tx_mac_ready, tx_mac_stat_valid, rx_mil_last;
  logic rx_mil_valid, rx_mil_ready, rx_mil_stat_valid, rx_mil_stat_ready;
  logic tx_error_flag, rx_error_flag, tx_halted_irq;
  logic [1:0] rx_mil_bytes;
  logic halted_seen = 1'b0;
  int checks = 0, miscompares = 0, cyc = 0, frames;
  hfd_row_t rows[6] = '{'{`HFD_A_LEVEL, 32'h0000_0000}, '{`HFD_A_FLAGS, 32'h0000_0000},
    '{`HFD_A_RXCFG, 32'h0000_0000}, '{`HFD_A_TXCFG, 32'h0000_0000},
    '{`HFD_A_DPCTRL, 32'h0000_0000}, '{8'h40, 32'h0000_0000}};
  always #5 sys_clk = ~sys_clk;
  hfd_datapath dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_mac_data(tx_mac_data),
    .tx_mac_last(tx_mac_last), .tx_mac_valid(tx_mac_valid), .tx_mac_ready(tx_mac_ready),
    .tx_mac_stat(tx_mac_stat), .tx_mac_stat_valid(tx_mac_stat_valid),
    .rx_mil_data(rx_mil_data), .rx_mil_last(rx_mil_last), .rx_mil_bytes(rx_mil_bytes),
    .rx_mil_valid(rx_mil_valid), .rx_mil_ready(rx_mil_ready), .rx_mil_stat(rx_mil_stat),
    .rx_mil_stat_valid(rx_mil_stat_valid), .rx_mil_stat_ready(rx_mil_stat_ready),
    .tx_error_flag(tx_error_flag), .rx_error_flag(rx_error_flag),
    .tx_halted_irq(tx_halted_irq));
  hfd_mac_model mdl (.sys_clk(sys_clk), .rst(rst), .tx_mac_data(tx_mac_data),
    .tx_mac_last(tx_mac_last), .tx_mac_valid(tx_mac_valid), .tx_mac_ready(tx_mac_ready),
    .tx_mac_stat(tx_mac_stat), .tx_mac_stat_valid(tx_mac_stat_valid),
    .rx_mil_data(rx_mil_data), .rx_mil_last(rx_mil_last), .rx_mil_bytes(rx_mil_bytes),
    .rx_mil_valid(rx_mil_valid), .rx_mil_ready(rx_mil_ready), .rx_mil_stat(rx_mil_stat),
    .rx_mil_stat_valid(rx_mil_stat_valid), .rx_mil_stat_ready(rx_mil_stat_ready),
    .frames(frames));
  // Halted pulse lasts one cycle, so latch it
  always @(posedge sys_clk) begin
    if (tx_halted_irq === 1'b1) halted_seen <= 1'b1;
  end
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // One idle edge before each strobe keeps drivers free of same-step reassignment
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      `CHK("reset read", rows[i].e, d)
    end
    $display("reset reads done");
    mdl.rx_pkt(1, 32'h1122_3344, 32'h0004_0000);
    rd(`HFD_A_LEVEL, d);
    `CHK("level", 32'h0001_0001, d)
    rd(`HFD_A_RXSTAT, d);
    `CHK("rx status", 32'h0004_0000, d)
    rd(`HFD_A_RXDATA, d);
    `CHK("rx data", 32'h1122_3344, d)
    $display("rx plain done");
    wr(`HFD_A_RXCFG, 32'h0000_0004);
    mdl.rx_pkt(1, 32'hCAFE_0001, 32'h0004_0000);
    rd(`HFD_A_LEVEL, d);
    `CHK("level offset", 32'h0001_0002, d)
    rd(`HFD_A_RXSTAT, d);
    rd(`HFD_A_RXDATA, d);
    rd(`HFD_A_RXDATA, d);
    `CHK("rx data offset", 32'hCAFE_0001, d)
    wr(`HFD_A_RXCFG, 32'h0000_0000);
    $display("rx offset done");
    mdl.rx_pkt(4, 32'h5000_0000, 32'h0010_0000);
    mdl.rx_pkt(1, 32'h6000_0000, 32'h0004_0000);
    wr(`HFD_A_DPCTRL, 32'h8000_0000);
    d = 32'hFFFF_FFFF;
    for (int i = 0; i < 20 && d[31] !== 1'b0; i++) rd(`HFD_A_DPCTRL, d);
    `CHK("skip clear", 1'b0, d[31])
    repeat (4) @(posedge sys_clk);
    rd(`HFD_A_LEVEL, d);
    `CHK("level skip", 32'h0002_0001, d)
    rd(`HFD_A_RXDATA, d);
    `CHK("data after skip", 32'h6000_0000, d)
    rd(`HFD_A_RXSTAT, d);
    rd(`HFD_A_RXSTAT, d);
    $display("skip done");
    rd(`HFD_A_RXDATA, d);
    @(posedge sys_clk);
    `CHK("underrun flag", 1'b1, rx_error_flag)
    wr(`HFD_A_FLAGS, 32'h8000_0000);
    repeat (3) @(posedge sys_clk);
    `CHK("flag after soft reset", 1'b0, rx_error_flag)
    $display("underrun done");
    wr(`HFD_A_RXCFG, 32'h0000_0100);
    mdl.rx_pkt(1, 32'h7000_0000, 32'h0004_0000);
    rd(`HFD_A_LEVEL, d);
    `CHK("level pad", 32'h0001_0004, d)
    wr(`HFD_A_RXCFG, 32'h0000_8000);
    rd(`HFD_A_LEVEL, d);
    `CHK("level flush", 32'h0000_0000, d)
    $display("pad done");
    wr(`HFD_A_TXCFG, 32'h0000_0001);
    wr(`HFD_A_TXDATA, 32'h0000_3004);
    wr(`HFD_A_TXDATA, 32'h0000_0008);
    wr(`HFD_A_TXDATA, 32'hA5A5_0001);
    repeat (20) @(posedge sys_clk);
    `CHK("tx length error", 1'b1, tx_error_flag)
    `CHK("frame sent", 1, frames)
    wr(`HFD_A_TXCFG, 32'h0000_0003);
    repeat (30) @(posedge sys_clk);
    `CHK("halted pulse", 1'b1, halted_seen)
    rd(`HFD_A_TXCFG, d);
    `CHK("tx cfg cleared", 32'h0000_0000, d)
    $display("tx halt done");
    wr(`HFD_A_FLAGS, 32'h0000_0001);
    @(posedge sys_clk);
    `CHK("tx error clear", 1'b0, tx_error_flag)
    wr(`HFD_A_TXDATA, 32'h0000_3104);
    wr(`HFD_A_TXDATA, 32'h0000_0104);
    for (int i = 0; i < 65; i++) wr(`HFD_A_TXDATA, 32'(i));
    @(posedge sys_clk);
    `CHK("tx overrun", 1'b1, tx_error_flag)
    $display("overrun done");
    final_report();
  end
endmodule
